// File: rtl/os_tick_pkg.sv
// constants shared by the os tick timer design
package os_tick_pkg;
  // ==========================================================================
  // register map (byte addresses)
  localparam logic [3:0] OFF_CURRENT_VALUE = 4'h0;
  localparam logic [3:0] OFF_RELOAD_VALUE  = 4'h4;
  localparam logic [3:0] OFF_CONTROL       = 4'h8;
  localparam logic [3:0] OFF_SOFT_IRQ      = 4'hC;
  localparam int         ADDR_W            = 4;
  localparam int         DATA_W            = 32;
  localparam int         STRB_W            = 4;
  localparam int         SOFT_IRQ_N        = 4;

  // ==========================================================================
  // control register fields
  localparam int CTL_BLOCK_ENABLE = 0;
  localparam int CTL_AUTO_RELOAD  = 1;
  localparam int CTL_START        = 2;
  localparam int CTL_DEBUG_FREEZE = 3;
  localparam int CTL_FW_HALT      = 4;
  localparam int CTL_W            = 5;

  // ==========================================================================
  // reset values
  localparam logic [31:0] COUNT_RESET   = 32'h0000_0000;
  localparam logic [31:0] RELOAD_RESET  = 32'h0000_0000;
  localparam logic [4:0]  CONTROL_RESET = 5'h00;
  localparam logic [31:0] COUNT_ONE     = 32'h0000_0001;

  // ==========================================================================
  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // timing: 100 MHz bus clock, 32.768 kHz tick period in ns
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_PERIOD_NS = 30518;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W     = 16;
endpackage

// File: rtl/tick_divider.sv
// divider that makes the slow timer tick from the bus clock
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int DIV   = 3051,
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // tick strobe
  output logic      tick
);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);

  logic [CNT_W-1:0] cnt_q;

  // free running count, one pulse every DIV cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q >= LAST) begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: rtl/low_power_os_tick_timer.sv
// 32-bit down counting os tick timer with axi4-lite register access
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module low_power_os_tick_timer #(
  parameter int TICK_DIV = os_tick_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // axi4-lite write address
  input  wire logic [os_tick_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  // axi4-lite write data
  input  wire logic [os_tick_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [os_tick_pkg::STRB_W-1:0] s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  // axi4-lite read address
  input  wire logic [os_tick_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  // axi4-lite read data
  output logic [os_tick_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // debug halt from the processor core
  input  wire logic                           debug_halt,
  // events and power status
  output logic                                os_tick_irq,
  output logic                                soft_irq_0,
  output logic                                soft_irq_1,
  output logic                                soft_irq_2,
  output logic                                soft_irq_3,
  output logic                                low_power_permit
);
  import os_tick_pkg::*;

  // ==========================================================================
  // state
  logic [DATA_W-1:0] count_q;
  logic [DATA_W-1:0] reload_q;
  logic [CTL_W-1:0]  ctl_q;
  logic              aw_full_q;
  logic              w_full_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [STRB_W-1:0] wstrb_q;
  logic              tick;
  logic              wr_fire;
  logic              wr_ok;
  logic [DATA_W-1:0] wr_word;
  logic [DATA_W-1:0] ctl_word;
  logic              running;
  logic              frozen;
  logic              step;
  logic [SOFT_IRQ_N-1:0] soft_q;
  // decoded strobes
  logic              ctl_wr;
  logic              reload_wr;
  logic              count_wr;
  logic              soft_wr;
  logic              start_rise;
  logic              expire;
  logic              wipe;

  // merges a write word into an old word by byte strobes
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                               input logic [DATA_W-1:0] new_v,
                                               input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================================
  // slow tick
  tick_divider #(
    .DIV   (TICK_DIV),
    .CNT_W (TICK_CNT_W)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  // ==========================================================================
  // write channel capture
  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
  assign wr_fire       = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wr_ok         = (awaddr_q[1:0] == 2'h0);
  assign ctl_word      = {{(DATA_W-CTL_W){1'b0}}, ctl_q};
  assign wr_word       = merge(ctl_word, wdata_q, wstrb_q);

  // hold the write address until the write data has come too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end

  // hold the write data and strobes until the address has come too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // timer core
  assign frozen  = ctl_q[CTL_FW_HALT] || (ctl_q[CTL_DEBUG_FREEZE] && debug_halt);
  assign running = ctl_q[CTL_BLOCK_ENABLE] && ctl_q[CTL_START];
  assign step    = running && !frozen && tick;

  // decoded write strobes, one per register
  assign ctl_wr     = wr_fire && wr_ok && (awaddr_q == OFF_CONTROL);
  assign reload_wr  = wr_fire && wr_ok && (awaddr_q == OFF_RELOAD_VALUE);
  assign count_wr   = wr_fire && wr_ok && (awaddr_q == OFF_CURRENT_VALUE);
  assign soft_wr    = wr_fire && wr_ok && (awaddr_q == OFF_SOFT_IRQ) && wstrb_q[0];
  assign start_rise = wr_word[CTL_START] && !ctl_q[CTL_START];
  assign expire     = step && (count_q == COUNT_ONE);
  // a control write decides by its new enable bit, otherwise the held one
  assign wipe       = ctl_wr ? !wr_word[CTL_BLOCK_ENABLE] : !ctl_q[CTL_BLOCK_ENABLE];

  // control bits; a software write wins over the hardware clearing start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= CONTROL_RESET;
    end else if (wipe) begin
      ctl_q <= CONTROL_RESET;
    end else if (ctl_wr) begin
      ctl_q <= wr_word[CTL_W-1:0];
      if (start_rise && reload_q == RELOAD_RESET) begin
        ctl_q[CTL_START] <= 1'b0;
      end
    end else if (expire && !count_wr && !ctl_q[CTL_AUTO_RELOAD]) begin
      ctl_q[CTL_START] <= 1'b0;
    end
  end

  // reload value, written by software and cleared while the block is disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_q <= RELOAD_RESET;
    end else if (wipe) begin
      reload_q <= RELOAD_RESET;
    end else if (reload_wr) begin
      reload_q <= merge(reload_q, wdata_q, wstrb_q);
    end
  end

  // down counter; a control or count write wins over a same-cycle tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= COUNT_RESET;
    end else if (wipe) begin
      count_q <= COUNT_RESET;
    end else if (ctl_wr) begin
      if (!wr_word[CTL_START]) begin
        count_q <= COUNT_RESET;
      end else if (start_rise && reload_q != RELOAD_RESET) begin
        count_q <= reload_q;
      end
    end else if (count_wr) begin
      count_q <= merge(count_q, wdata_q, wstrb_q);
    end else if (expire && ctl_q[CTL_AUTO_RELOAD]) begin
      count_q <= reload_q;
    end else if (expire) begin
      count_q <= COUNT_RESET;
    end else if (step && count_q != COUNT_RESET) begin
      count_q <= count_q - COUNT_ONE;
    end
  end

  // one-cycle tick irq; a control or count write at expiry overrides the count update and drops this irq
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      os_tick_irq <= 1'b0;
    end else begin
      os_tick_irq <= expire && !ctl_wr && !count_wr;
    end
  end

  // ==========================================================================
  // power status
  // the timer counts as active while started, halted or not
  assign low_power_permit = !running;

  // ==========================================================================
  // software interrupt pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_q <= '0;
    end else if (soft_wr) begin
      soft_q <= wdata_q[SOFT_IRQ_N-1:0];
    end else begin
      soft_q <= '0;
    end
  end

  assign soft_irq_0 = soft_q[0];
  assign soft_irq_1 = soft_q[1];
  assign soft_irq_2 = soft_q[2];
  assign soft_irq_3 = soft_q[3];

  // ==========================================================================
  // read channel
  assign s_axi_arready = !s_axi_rvalid;

  // read valid stands until the master takes the data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // registered read data, live count on every read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= '0;
      if (s_axi_araddr[1:0] != 2'h0) begin
        s_axi_rresp <= RESP_SLVERR;
      end else if (s_axi_araddr == OFF_CURRENT_VALUE) begin
        s_axi_rdata <= count_q;
      end else if (s_axi_araddr == OFF_RELOAD_VALUE) begin
        s_axi_rdata <= reload_q;
      end else if (s_axi_araddr == OFF_CONTROL) begin
        s_axi_rdata <= ctl_word;
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/low_power_os_tick_timer_sva.sv
// port checker for the os tick timer
`timescale 1ns/1ps
`default_nettype none
module os_tick_sva (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // events and power status
  input wire logic        os_tick_irq,
  input wire logic        soft_irq_0,
  input wire logic        soft_irq_1,
  input wire logic        soft_irq_2,
  input wire logic        soft_irq_3,
  input wire logic        low_power_permit
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // read request steps
  sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence rd_bad; rd_taken ##0 (s_axi_araddr[1:0] != 2'h0); endsequence
  sequence rd_soft; rd_taken ##0 (s_axi_araddr == 4'hC); endsequence
  // ==========================================================================
  // timer events
  a_irq_pulse: assert property (os_tick_irq |=> !os_tick_irq)
    else $error("tick irq longer than one cycle");
  a_irq_was_busy: assert property (os_tick_irq |-> !$past(low_power_permit))
    else $error("tick irq while timer idle");
  a_soft_pulse: assert property (soft_irq_1 |=> !soft_irq_1)
    else $error("soft irq longer than one cycle");
  a_soft_on_write: assert property ((soft_irq_0 || soft_irq_1 || soft_irq_2 || soft_irq_3)
    |-> $rose(s_axi_bvalid)) else $error("soft irq without write");
  a_reset_clears: assert property (disable iff (1'b0) !aresetn |=>
    !os_tick_irq && low_power_permit && !s_axi_bvalid && !s_axi_rvalid)
    else $error("reset did not clear outputs");
  // ==========================================================================
  // register bus answers
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
  a_unaligned_err: assert property (rd_bad |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unaligned read not refused");
  a_soft_read_zero: assert property (rd_soft |=> s_axi_rdata == 32'h0)
    else $error("soft irq register read not zero");
endmodule
`default_nettype wire

// File: dv/test_low_power_os_tick_timer.sv
// self-checking bench for the os tick timer
`timescale 1ns/1ps
`default_nettype none
module test_low_power_os_tick_timer;
  import os_tick_pkg::*;
  // stimulus
  logic        aclk = 1'b0, aresetn = 1'b0, debug_halt = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = '0;
  // responses
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        os_tick_irq, soft_irq_0, soft_irq_1, soft_irq_2, soft_irq_3, low_power_permit;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, v;
  logic [3:0]  sirq;
  int          n_mismatch = 0, n_checks = 0, n_irq = 0, k;

  low_power_os_tick_timer #(.TICK_DIV(4)) DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .debug_halt, .os_tick_irq, .soft_irq_0, .soft_irq_1, .soft_irq_2, .soft_irq_3,
    .low_power_permit);

  // 100 MHz clock
  always #5 aclk = ~aclk;
  // count tick irq pulses
  always @(posedge aclk) begin
    if (os_tick_irq === 1'b1) n_irq++;
  end

  // ==========================================================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // write with both channels offered together, bready raised late
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b0;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) begin
        sirq = {soft_irq_3, soft_irq_2, soft_irq_1, soft_irq_0};
        s_axi_bready <= 1'b1;
      end
    end
    r = s_axi_bresp;
  endtask
  // read with rready raised late
  task automatic rd(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b0;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    v = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rdck(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    ck(v, e);
  endtask
  // wait a bounded time for the next tick irq
  task automatic wirq(input int lim);
    int n = 0;
    k = n_irq;
    while (n_irq == k && n < lim) begin
      @(posedge aclk);
      n++;
    end
    ck(n < lim, 1'b1);
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    cyc(4);
    aresetn <= 1'b1;
    cyc(1);
    rdck(OFF_CURRENT_VALUE, COUNT_RESET);
    rdck(OFF_RELOAD_VALUE, RELOAD_RESET);
    rdck(OFF_CONTROL, 32'h0);
    rdck(OFF_SOFT_IRQ, 32'h0);
    rd(4'h2);
    ck(r, RESP_SLVERR);
    wr(4'h6, 32'h1);
    ck(r, RESP_SLVERR);
    // disable wipes the reload value; zero reload refuses start
    wr(OFF_CONTROL, 32'h1);
    wr(OFF_RELOAD_VALUE, 32'h5);
    rdck(OFF_RELOAD_VALUE, 32'h5);
    wr(OFF_CONTROL, 32'h0);
    rdck(OFF_RELOAD_VALUE, 32'h0);
    wr(OFF_CONTROL, 32'h1);
    wr(OFF_CONTROL, 32'h5);
    rdck(OFF_CONTROL, 32'h1);
    // firmware halt freezes, resume decrements one per tick
    wr(OFF_RELOAD_VALUE, 32'h64);
    wr(OFF_CONTROL, 32'h15);
    ck(low_power_permit, 1'b0);
    rdck(OFF_CURRENT_VALUE, 32'h64);
    cyc(20);
    rdck(OFF_CURRENT_VALUE, 32'h64);
    wr(OFF_CONTROL, 32'h5);
    cyc(40);
    wr(OFF_CONTROL, 32'h15);
    rd(OFF_CURRENT_VALUE);
    ck(v <= 32'h5C && v >= 32'h57, 1'b1);
    rdck(OFF_CURRENT_VALUE, v);
    // debug halt obeyed only while its enable is set
    debug_halt <= 1'b1;
    wr(OFF_CONTROL, 32'hD);
    rd(OFF_CURRENT_VALUE);
    cyc(20);
    rdck(OFF_CURRENT_VALUE, v);
    wr(OFF_CONTROL, 32'h5);
    cyc(20);
    rd(OFF_CURRENT_VALUE);
    ck(v < 32'h57, 1'b1);
    debug_halt <= 1'b0;
    // clearing start zeroes the count silently
    k = n_irq;
    wr(OFF_CONTROL, 32'h1);
    rdck(OFF_CURRENT_VALUE, 32'h0);
    cyc(40);
    ck(n_irq, k);
    ck(low_power_permit, 1'b1);
    // one-shot expiry stops and clears start
    wr(OFF_RELOAD_VALUE, 32'h3);
    wr(OFF_CONTROL, 32'h5);
    wirq(20);
    rdck(OFF_CONTROL, 32'h1);
    rdck(OFF_CURRENT_VALUE, 32'h0);
    cyc(40);
    ck(n_irq, k + 1);
    // continuous run picks up the new reload only at expiry
    wr(OFF_CONTROL, 32'h7);
    wr(OFF_RELOAD_VALUE, 32'h32);
    wirq(20);
    rd(OFF_CURRENT_VALUE);
    ck(v <= 32'h32 && v >= 32'h2F, 1'b1);
    rdck(OFF_CONTROL, 32'h7);
    wr(OFF_CONTROL, 32'h17);
    wr(OFF_CURRENT_VALUE, 32'h89AB_CDEF);
    rdck(OFF_CURRENT_VALUE, 32'h89AB_CDEF);
    s_axi_wstrb <= 4'h1;
    wr(OFF_CURRENT_VALUE, 32'h0000_0012);
    s_axi_wstrb <= 4'hF;
    rdck(OFF_CURRENT_VALUE, 32'h89AB_CD12);
    wr(OFF_SOFT_IRQ, 32'hA);
    ck(sirq, 4'hA);
    wr(OFF_SOFT_IRQ, 32'h5);
    ck(sirq, 4'h5);
    // reset in mid-run
    aresetn <= 1'b0;
    cyc(4);
    aresetn <= 1'b1;
    cyc(1);
    rdck(OFF_CONTROL, 32'h0);
    rdck(OFF_CURRENT_VALUE, 32'h0);
    complete_run;
  end

  // watchdog against a hung handshake
  initial begin
    cyc(20000);
    n_mismatch++;
    complete_run;
  end
endmodule
bind low_power_os_tick_timer os_tick_sva u_sva (.aclk, .aresetn, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .os_tick_irq, .soft_irq_0,
  .soft_irq_1, .soft_irq_2, .soft_irq_3, .low_power_permit);
`default_nettype wire
